// ===== core/light_prox_sensor_regs.sv
// register map, interrupt flags and led pulse control of the sensor
// assumes an analog front end feeding raw counts and bus pins synced to clk
`timescale 1ns/10ps
`default_nettype none
// Operation
// - ambient result in two read-only bytes
// - ambient in difference mode equals gained green minus gained ir
// - mode selects green, ir or difference
// - proximity eight-bit result in read-only register
// - rejection sampling synced to each led pulse
// - four-bit drive code, 10 mA steps
// - status register read-only, resets 0x04
// - main config read/write, resets 0x24
// - receive config time and gain, reset zero
// - upper limit fourteen bits, two bytes
// - lower limit fourteen bits, two bytes
// - host gain trims applied to channels
// - interrupt pin low while flags set; power-up flag counts only when REV_ONE is 0
// - status read clears; disable forces zero
// - ambient flag on persistent excursion or overflow
module light_prox_sensor_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h4a,  // arbitrary bus address
  parameter logic REV_ONE = 1'b0  // first revision: power-up flag ignored on pin
) (
  input wire logic clk,  // 100 MHz clock
  input wire logic sys_rst,  // sync reset, high
  input wire light_prox_pkg::i2c_pins_t pins,  // scl/sda levels
  output logic sda_oe_n,  // low pulls sda low
  output logic irq_n,  // interrupt pin, active low
  input wire light_prox_pkg::adc_raw_t adc,  // front-end samples
  output logic led_pulse,  // led pulse request
  output logic [3:0] led_current_code,  // led amplitude code
  output logic rejection_sample  // ambient rejection strobe
);
  typedef struct packed {
    logic [2:0] flags;  // power-up, proximity, ambient
    logic [7:0] main_cfg;
    logic [7:0] rx_cfg;
    logic [3:0] drive;
    logic [13:0] amb;
    logic amb_ofl;
    logic [13:0] up_lim;
    logic [13:0] lo_lim;
    logic [7:0] persist;
    logic [7:0] trim_g;
    logic [7:0] trim_i;
    logic [7:0] prox;
    logic [2:0] out_cnt;  // consecutive out-of-window results
    logic irq_n;
    logic pulse;
    logic rej;
    logic sda_oe_n;
  } st_t;
  st_t cur_ff, nxt_st;
  light_prox_pkg::reg_req_t req;
  logic bus_oe_n;
  logic [7:0] rdata;
  logic calc_v, calc_ofl, outside;
  logic [13:0] calc_res;
  logic [2:0] pst_need;
  // i2c target with pointer, handled inside
  i2c_target #(.DEV_ADDR(DEV_ADDR)) u_bus (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins(pins),
    .rdata(rdata),
    .req(req),
    .sda_oe_n(bus_oe_n)
  );
  // ambient arithmetic
  ambient_calc u_calc (
    .clk(clk),
    .sys_rst(sys_rst),
    .valid_in(adc.amb_valid),
    .green(adc.green),
    .ir(adc.ir),
    .trim_green(cur_ff.trim_g),
    .trim_ir(cur_ff.trim_i),
    .trim_en(cur_ff.main_cfg[light_prox_pkg::BIT_TRIM_EN]),
    .gain_sel(cur_ff.rx_cfg[1:0]),
    .mode(cur_ff.main_cfg[light_prox_pkg::MODE_LSB +: 3]),
    .valid_out(calc_v),
    .result(calc_res),
    .overflow(calc_ofl)
  );
  // read mux decoded from the pointer
  function automatic logic [7:0] read_byte(input st_t s, input logic [7:0] a);
    case (a)
      light_prox_pkg::ADDR_IRQ_FLAGS: read_byte = {5'h0, s.flags};
      light_prox_pkg::ADDR_MAIN_CONFIG: read_byte = s.main_cfg;
      light_prox_pkg::ADDR_RECEIVE_CONFIG: read_byte = s.rx_cfg;
      light_prox_pkg::ADDR_LED_DRIVE: read_byte = {4'h0, s.drive};
      light_prox_pkg::ADDR_AMB_HIGH: read_byte = {1'b0, s.amb_ofl, s.amb[13:8]};
      light_prox_pkg::ADDR_AMB_LOW: read_byte = s.amb[7:0];
      light_prox_pkg::ADDR_UPPER_HIGH: read_byte = {2'h0, s.up_lim[13:8]};
      light_prox_pkg::ADDR_UPPER_LOW: read_byte = s.up_lim[7:0];
      light_prox_pkg::ADDR_LOWER_HIGH: read_byte = {2'h0, s.lo_lim[13:8]};
      light_prox_pkg::ADDR_LOWER_LOW: read_byte = s.lo_lim[7:0];
      light_prox_pkg::ADDR_PERSIST: read_byte = s.persist;
      light_prox_pkg::ADDR_TRIM_GREEN: read_byte = s.trim_g;
      light_prox_pkg::ADDR_TRIM_IR: read_byte = s.trim_i;
      light_prox_pkg::ADDR_PROX_RESULT: read_byte = s.prox;
      default: read_byte = 8'h00;  // unmapped reads as zero
    endcase
  endfunction
  // persist count to consecutive out-of-window results needed: 1, 4, 6 or 8
  always_comb begin
    case (cur_ff.persist[1:0])
      2'h0: pst_need = 3'h0;
      2'h1: pst_need = 3'h3;
      2'h2: pst_need = 3'h5;
      default: pst_need = 3'h7;
    endcase
    rdata = read_byte(cur_ff, req.addr);
    outside = (calc_res > cur_ff.up_lim) | (calc_res < cur_ff.lo_lim);
  end
  // register, flag and led sequencing
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.pulse = 1'b0;
    nxt_st.rej = 1'b0;
    nxt_st.sda_oe_n = bus_oe_n;
    if (req.wr) begin  // host writes; read-only addresses ignored
      case (req.addr)
        light_prox_pkg::ADDR_MAIN_CONFIG: nxt_st.main_cfg = req.wdata;
        light_prox_pkg::ADDR_RECEIVE_CONFIG: nxt_st.rx_cfg = req.wdata & light_prox_pkg::MASK_LOW4;
        light_prox_pkg::ADDR_LED_DRIVE: begin
          nxt_st.drive = (req.wdata[3:0] > light_prox_pkg::LED_MAX_CODE) ?
                         light_prox_pkg::LED_MAX_CODE : req.wdata[3:0];
        end
        light_prox_pkg::ADDR_UPPER_HIGH: nxt_st.up_lim[13:8] = req.wdata[5:0];
        light_prox_pkg::ADDR_UPPER_LOW: nxt_st.up_lim[7:0] = req.wdata;
        light_prox_pkg::ADDR_LOWER_HIGH: nxt_st.lo_lim[13:8] = req.wdata[5:0];
        light_prox_pkg::ADDR_LOWER_LOW: nxt_st.lo_lim[7:0] = req.wdata;
        light_prox_pkg::ADDR_PERSIST: nxt_st.persist = req.wdata;
        light_prox_pkg::ADDR_TRIM_GREEN: nxt_st.trim_g = req.wdata;
        light_prox_pkg::ADDR_TRIM_IR: nxt_st.trim_i = req.wdata;
        default: ;
      endcase
    end
    // status read clears all flags; events below still win
    if (req.rd && req.addr == light_prox_pkg::ADDR_IRQ_FLAGS) begin
      nxt_st.flags = 3'h0;
    end
    if (calc_v) begin  // new ambient result
      nxt_st.amb = calc_res;
      nxt_st.amb_ofl = calc_ofl;
      nxt_st.out_cnt = outside ? ((cur_ff.out_cnt == pst_need) ? cur_ff.out_cnt
                                  : cur_ff.out_cnt + 3'h1) : 3'h0;
      if ((outside && cur_ff.out_cnt == pst_need) || calc_ofl) begin
        nxt_st.flags[light_prox_pkg::BIT_AMB_IRQ] = 1'b1;
      end
    end
    if (adc.prox_valid) begin
      nxt_st.prox = adc.prox;
      nxt_st.pulse = cur_ff.drive != 4'h0;  // one pulse per conversion, none while the drive code is zero
      nxt_st.rej = 1'b1;
      if (cur_ff.main_cfg[light_prox_pkg::BIT_PROX_IRQ] && adc.prox != 8'h00) begin
        nxt_st.flags[light_prox_pkg::BIT_PROX_IRQ] = 1'b1;
      end
    end
    // disabled enables hold their flags at zero
    if (!nxt_st.main_cfg[light_prox_pkg::BIT_AMB_IRQ]) nxt_st.flags[light_prox_pkg::BIT_AMB_IRQ] = 1'b0;
    if (!nxt_st.main_cfg[light_prox_pkg::BIT_PROX_IRQ]) nxt_st.flags[light_prox_pkg::BIT_PROX_IRQ] = 1'b0;
    nxt_st.irq_n = ~(|nxt_st.flags[1:0] | (nxt_st.flags[light_prox_pkg::BIT_POWER_UP] & ~REV_ONE));
  end
  // state register with documented reset values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.flags <= light_prox_pkg::RST_IRQ_FLAGS[2:0];
      cur_ff.main_cfg <= light_prox_pkg::RST_MAIN_CONFIG;
      cur_ff.rx_cfg <= light_prox_pkg::RST_ZERO;
      cur_ff.trim_g <= light_prox_pkg::RST_TRIM;
      cur_ff.trim_i <= light_prox_pkg::RST_TRIM;
      cur_ff.irq_n <= REV_ONE;
      cur_ff.sda_oe_n <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end
  assign sda_oe_n = cur_ff.sda_oe_n;
  assign irq_n = cur_ff.irq_n;
  assign led_pulse = cur_ff.pulse;
  assign led_current_code = cur_ff.drive;
  assign rejection_sample = cur_ff.rej;
  // checks
  sequence s_status_read;
    req.rd && req.addr == light_prox_pkg::ADDR_IRQ_FLAGS && !calc_v && !adc.prox_valid;
  endsequence
  chk_read_clears: assert property (@(posedge clk) disable iff (sys_rst)
    s_status_read |=> cur_ff.flags == 3'h0) else $error("status read did not clear flags");
  chk_irq_pin: assert property (@(posedge clk) disable iff (sys_rst)
    (|cur_ff.flags[1:0]) |-> !irq_n) else $error("irq pin high with flag set");
  chk_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !cur_ff.main_cfg[0] |-> !cur_ff.flags[0]) else $error("ambient flag set while disabled");
  chk_amb_result: assert property (@(posedge clk) disable iff (sys_rst)
    calc_v |=> cur_ff.amb == $past(calc_res)) else $error("ambient result not stored");
  chk_ovf_flag: assert property (@(posedge clk) disable iff (sys_rst)
    calc_v && calc_ofl && cur_ff.main_cfg[0] && !req.wr |=> cur_ff.flags[0]) else $error("overflow no flag");
  chk_prox_store: assert property (@(posedge clk) disable iff (sys_rst)
    adc.prox_valid |=> cur_ff.prox == $past(adc.prox) && rejection_sample) else $error("prox not stored");
  chk_pulse_sync: assert property (@(posedge clk) disable iff (sys_rst)
    led_pulse |-> rejection_sample) else $error("pulse without rejection sample");
  chk_drive_limit: assert property (@(posedge clk) disable iff (sys_rst)
    led_current_code <= light_prox_pkg::LED_MAX_CODE) else $error("led code above 110 mA");
  chk_ro_result: assert property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == light_prox_pkg::ADDR_AMB_LOW && !calc_v |=> $stable(cur_ff.amb))
    else $error("read-only result written");
  chk_rx_mask: assert property (@(posedge clk) disable iff (sys_rst)
    cur_ff.rx_cfg[7:4] == 4'h0) else $error("receive config upper bits set");
endmodule // light_prox_sensor_regs
`default_nettype wire

// ===== include/light_prox_pkg.sv
// package for the light and proximity sensor register block
// assumes one 100 MHz clock and a synchronous active-high reset
package light_prox_pkg;
  // register offsets (byte pointer values)
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_MAIN_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_RECEIVE_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_LED_DRIVE = 8'h03;
  localparam logic [7:0] ADDR_AMB_HIGH = 8'h04;
  localparam logic [7:0] ADDR_AMB_LOW = 8'h05;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'h06;
  localparam logic [7:0] ADDR_UPPER_LOW = 8'h07;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'h08;
  localparam logic [7:0] ADDR_LOWER_LOW = 8'h09;
  localparam logic [7:0] ADDR_PERSIST = 8'h0a;
  localparam logic [7:0] ADDR_TRIM_GREEN = 8'h0f;
  localparam logic [7:0] ADDR_TRIM_IR = 8'h10;
  localparam logic [7:0] ADDR_PROX_RESULT = 8'h16;
  // reset values
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h04;
  localparam logic [7:0] RST_MAIN_CONFIG = 8'h24;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h80;
  // field positions
  localparam int BIT_AMB_IRQ = 0;
  localparam int BIT_PROX_IRQ = 1;
  localparam int BIT_POWER_UP = 2;
  localparam int MODE_LSB = 2;
  localparam int BIT_TRIM_EN = 5;
  localparam int LIMIT_HIGH_BITS = 6;
  localparam int OVF_BIT = 6;
  localparam logic [7:0] MASK_LOW6 = 8'h3f;
  localparam logic [7:0] MASK_LOW4 = 8'h0f;
  // ambient output selections of the mode field
  localparam logic [2:0] MODE_GREEN_ONLY = 3'h1;
  localparam logic [2:0] MODE_IR_ONLY = 3'h2;
  // led drive: 10 mA per code step, 110 mA ceiling
  localparam int LED_STEP_MA = 10;
  localparam int LED_MAX_MA = 110;
  localparam logic [3:0] LED_MAX_CODE = 4'(LED_MAX_MA / LED_STEP_MA);
  // 14-bit result ceiling
  localparam logic [13:0] AMB_FULL = 14'h3fff;
  // i2c bus signals after synchronisation
  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_pins_t;
  // raw converter samples from the analog front end
  typedef struct packed {
    logic amb_valid;  // ambient conversion done
    logic [13:0] green;  // green channel count
    logic [13:0] ir;  // infrared channel count
    logic prox_valid;  // proximity conversion done
    logic [7:0] prox;  // proximity count
  } adc_raw_t;
  // register-side access strobes from the i2c target
  typedef struct packed {
    logic wr;  // one-cycle write strobe
    logic rd;  // one-cycle read strobe (byte taken)
    logic [7:0] addr;  // register pointer
    logic [7:0] wdata;  // write byte
  } reg_req_t;
endpackage

// ===== core/i2c_target.sv
// i2c target: pointer byte then data bytes, auto increment
// assumes scl/sda synchronous to clk; 7-bit address is a parameter
`timescale 1ns/10ps
`default_nettype none
module i2c_target #(
  parameter logic [6:0] DEV_ADDR = 7'h4a  // arbitrary bus address
) (
  input wire logic clk,  // system clock
  input wire logic sys_rst,  // sync reset
  input wire light_prox_pkg::i2c_pins_t pins,  // bus levels
  input wire logic [7:0] rdata,  // byte at pointer
  output light_prox_pkg::reg_req_t req,  // register access
  output logic sda_oe_n  // low pulls sda low
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_SHIFT = 4'b0010, S_ACK = 4'b0100, S_SEND = 4'b1000
  } phase_t;
  typedef struct packed {
    phase_t ph;
    logic scl;
    logic sda;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rnw;
    logic [1:0] byte_no;
    logic [7:0] ptr;
    logic drive_low;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } st_t;
  st_t cur_ff, nxt_st;
  logic rise, fall, start, stop;
  // edge and condition detection on the synchronised bus
  always_comb begin
    rise = pins.scl & ~cur_ff.scl;
    fall = ~pins.scl & cur_ff.scl;
    start = pins.scl & cur_ff.scl & cur_ff.sda & ~pins.sda;
    stop = pins.scl & cur_ff.scl & ~cur_ff.sda & pins.sda;
  end
  // protocol sequencer
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.scl = pins.scl;
    nxt_st.sda = pins.sda;
    nxt_st.wr = 1'b0;
    nxt_st.rd = 1'b0;
    if (start) begin  // (re)start: fresh address byte
      nxt_st.ph = S_SHIFT;
      nxt_st.cnt = 4'h0;
      nxt_st.byte_no = 2'h0;
      nxt_st.drive_low = 1'b0;
    end else if (stop) begin
      nxt_st.ph = S_IDLE;
      nxt_st.drive_low = 1'b0;
    end else begin
      case (cur_ff.ph)
        S_IDLE: nxt_st.drive_low = 1'b0;
        S_SHIFT: begin
          if (rise) begin
            nxt_st.sh = {cur_ff.sh[6:0], pins.sda};
            nxt_st.cnt = cur_ff.cnt + 4'h1;
          end
          if (fall && cur_ff.cnt == 4'h8) begin  // byte complete
            nxt_st.cnt = 4'h0;
            if (cur_ff.byte_no == 2'h0) begin
              nxt_st.rnw = cur_ff.sh[0];
              if (cur_ff.sh[7:1] == DEV_ADDR) begin
                nxt_st.ph = S_ACK;
                nxt_st.drive_low = 1'b1;
              end else begin
                nxt_st.ph = S_IDLE;
              end
            end else begin
              nxt_st.ph = S_ACK;
              nxt_st.drive_low = 1'b1;
              if (cur_ff.byte_no == 2'h1) begin
                nxt_st.ptr = cur_ff.sh;
              end else begin
                nxt_st.wr = 1'b1;  // data byte to register
                nxt_st.wdata = cur_ff.sh;
              end
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            if (cur_ff.byte_no == 2'h2) begin
              nxt_st.ptr = cur_ff.ptr + 8'h01;  // advance after write
            end
            if (cur_ff.byte_no != 2'h2) begin
              nxt_st.byte_no = cur_ff.byte_no + 2'h1;
            end
            if (cur_ff.rnw) begin  // read: present byte at pointer
              nxt_st.ph = S_SEND;
              nxt_st.sh = rdata;
              nxt_st.rd = 1'b1;
              nxt_st.drive_low = ~rdata[7];
              nxt_st.cnt = 4'h1;
            end else begin
              nxt_st.ph = S_SHIFT;
              nxt_st.drive_low = 1'b0;
            end
          end
        end
        S_SEND: begin
          if (fall) begin
            if (cur_ff.cnt == 4'h8) begin  // release for master ack
              nxt_st.drive_low = 1'b0;
              nxt_st.cnt = 4'h9;
              nxt_st.ptr = cur_ff.ptr + 8'h01;
            end else if (cur_ff.cnt == 4'h9) begin
              nxt_st.sh = rdata;
              nxt_st.rd = 1'b1;
              nxt_st.drive_low = ~rdata[7];
              nxt_st.cnt = 4'h1;
            end else begin
              nxt_st.drive_low = ~cur_ff.sh[3'(7 - cur_ff.cnt)];
              nxt_st.cnt = cur_ff.cnt + 4'h1;
            end
          end
          if (rise && cur_ff.cnt == 4'h9 && pins.sda) begin
            nxt_st.ph = S_IDLE;  // master nack ends the read
          end
        end
        default: nxt_st.ph = S_IDLE;
      endcase
    end
  end
  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '{ph: S_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      cur_ff <= nxt_st;
    end
  end
  assign req = '{wr: cur_ff.wr, rd: cur_ff.rd, addr: cur_ff.ptr, wdata: cur_ff.wdata};
  assign sda_oe_n = ~cur_ff.drive_low;
endmodule // i2c_target
`default_nettype wire

// ===== core/ambient_calc.sv
// ambient arithmetic: trimmed, gained green, ir or green minus ir by mode, 14-bit clamp
// assumes raw counts valid in the cycle of amb_valid
`timescale 1ns/10ps
`default_nettype none
module ambient_calc (
  input wire logic clk,  // system clock
  input wire logic sys_rst,  // sync reset
  input wire logic valid_in,  // raw sample strobe
  input wire logic [13:0] green,  // green count
  input wire logic [13:0] ir,  // ir count
  input wire logic [7:0] trim_green,  // green trim, 0x80 unity
  input wire logic [7:0] trim_ir,  // ir trim, 0x80 unity
  input wire logic trim_en,  // apply trims
  input wire logic [1:0] gain_sel,  // gain shift
  input wire logic [2:0] mode,  // output selection
  output logic valid_out,  // result strobe
  output logic [13:0] result,  // clamped result
  output logic overflow  // result clamped
);
  typedef struct packed {
    logic v;
    logic [13:0] res;
    logic ambient_overflow_flag;
  } st_t;
  st_t cur_ff, nxt_st;
  logic [24:0] g_sc, i_sc, pick;
  // trim scale and gain shift of one channel
  function automatic logic [24:0] scale(input logic [13:0] c, input logic [7:0] t,
                                        input logic en, input logic [1:0] g);
    logic [21:0] p;
    p = en ? (22'(c) * 22'(t)) : {1'b0, c, 7'h00};
    scale = 25'({p, 3'h0} >> (4'h3 - {2'h0, g}) >> 7);
  endfunction
  // channel selection and subtraction, clamped
  always_comb begin
    g_sc = scale(green, trim_green, trim_en, gain_sel);
    i_sc = scale(ir, trim_ir, trim_en, gain_sel);
    case (mode)
      light_prox_pkg::MODE_GREEN_ONLY: pick = g_sc;
      light_prox_pkg::MODE_IR_ONLY: pick = i_sc;
      default: pick = (g_sc > i_sc) ? g_sc - i_sc : 25'h0;
    endcase
    nxt_st = cur_ff;
    nxt_st.v = valid_in;
    if (valid_in) begin
      nxt_st.ambient_overflow_flag = pick > 25'(light_prox_pkg::AMB_FULL);
      nxt_st.res = nxt_st.ambient_overflow_flag ? light_prox_pkg::AMB_FULL : pick[13:0];
    end
  end
  // result register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end
  assign valid_out = cur_ff.v;
  assign result = cur_ff.res;
  assign overflow = cur_ff.ambient_overflow_flag;
endmodule // ambient_calc
`default_nettype wire

// ===== testbench/i2c_host_model.sv
// host-side i2c bus model: drives scl and an open-drain sda
// assumes sda is resolved outside with a pull-up; clk only paces bits
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,  // pacing clock
  input wire logic sda_in,  // resolved sda level
  output logic scl,  // bus clock, idles high
  output logic sda_drv  // low pulls sda low
);
  // idle: both lines released, clock stands still
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // one phase: change lines after a falling edge, hold for 4 clocks
  task automatic ph(input logic c, input logic d);
    @(negedge clk);
    scl = c;
    sda_drv = d;
    repeat (3) @(negedge clk);
  endtask
  // start: sda falls while scl is high
  task automatic start();
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  // repeated start: release sda with scl low first
  task automatic rstart();
    ph(1'b0, 1'b1);
    start();
  endtask
  // stop: sda rises while scl is high
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // one bit: data set while scl low, sampled at the end of the high phase
  task automatic bit_io(input logic d, output logic r);
    ph(1'b0, d);
    ph(1'b1, d);
    r = sda_in;
  endtask
  // byte out msb first; returns the ninth bit (0 = acknowledged)
  task automatic byte_out(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], nack);
    end
    bit_io(1'b1, nack);
  endtask
  // byte in msb first, then host ack (0) or nack (1)
  task automatic byte_in(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the sensor register block over its i2c port
// assumes the host model compiles first; one 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [6:0] DA = 7'h4a;  // bus address, arbitrary
  logic clk;  // system clock
  logic sys_rst;  // sync reset
  logic scl;  // host bus clock
  logic sda_drv;  // host sda drive
  logic sda_oe_n;  // device sda drive
  logic sda;  // resolved sda with pull-up
  logic irq_n;  // interrupt pin
  logic led_pulse;  // led pulse request
  logic [3:0] led_current_code;  // led code
  logic rejection_sample;  // rejection strobe
  light_prox_pkg::i2c_pins_t pins;  // bus levels into the device
  light_prox_pkg::adc_raw_t adc;  // front-end samples
  int err_count = 0;  // mismatches
  int checked = 0;  // comparisons
  int cycles = 0;  // timeout counter
  logic nk;  // nack seen
  logic lp;  // led pulse seen
  logic both;  // led pulse with rejection strobe seen
  // reset table, write table and mode table
  logic [7:0] ra [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h16, 8'h30};
  logic [7:0] rv [11] = '{0: 8'h24, default: 8'h00};
  logic [7:0] wa [7] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09};
  logic [7:0] wd [7] = '{8'h1c, 8'h0f, 8'h05, 8'hff, 8'ha5, 8'hff, 8'h5a};
  logic [7:0] we [7] = '{8'h1c, 8'h0f, 8'h05, 8'h3f, 8'ha5, 8'h3f, 8'h5a};
  logic [7:0] mc [3] = '{8'h04, 8'h08, 8'h00};
  logic [13:0] mx [3] = '{14'h1000, 14'h0400, 14'h0c00};
  // open-drain sda: either side may pull low
  assign sda = sda_drv & sda_oe_n;
  assign pins = {scl, sda};
  light_prox_sensor_regs #(.DEV_ADDR(DA), .REV_ONE(1'b0)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .pins(pins), .sda_oe_n(sda_oe_n), .irq_n(irq_n), .adc(adc),
    .led_pulse(led_pulse), .led_current_code(led_current_code), .rejection_sample(rejection_sample));
  i2c_host_model host_u (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic end_sim();
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      end_sim();
    end
  end
  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // register write: address, pointer, data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic n0, n1, n2;
    host_u.start();
    host_u.byte_out({DA, 1'b0}, n0);
    host_u.byte_out(a, n1);
    host_u.byte_out(d, n2);
    host_u.stop();
    chk({7'h00, n0 | n1 | n2}, 8'h00);
  endtask
  // register read with repeated start, compared to exp
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic n;
    logic [7:0] d;
    host_u.start();
    host_u.byte_out({DA, 1'b0}, n);
    host_u.byte_out(a, n);
    host_u.rstart();
    host_u.byte_out({DA, 1'b1}, n);
    host_u.byte_in(1'b1, d);
    host_u.stop();
    chk(d, exp);
  endtask
  // one ambient conversion from the front end
  task automatic amb(input logic [13:0] g, input logic [13:0] i);
    @(negedge clk);
    adc.green = g;
    adc.ir = i;
    adc.amb_valid = 1'b1;
    @(negedge clk);
    adc.amb_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // one proximity conversion; watches the led and rejection strobes
  task automatic prox(input logic [7:0] v);
    @(negedge clk);
    adc.prox = v;
    adc.prox_valid = 1'b1;
    lp = 1'b0;
    both = 1'b0;
    repeat (4) begin
      @(negedge clk);
      adc.prox_valid = 1'b0;
      lp = lp | (led_pulse === 1'b1);
      both = both | (led_pulse === 1'b1 && rejection_sample === 1'b1);
    end
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    adc = '0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk({7'h00, irq_n}, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h55);
    wr(8'h16, 8'h55);
    rc(8'h00, 8'h04);
    chk({7'h00, irq_n}, 8'h01);
    rc(8'h00, 8'h00);
    for (int i = 0; i < 11; i++) rc(ra[i], rv[i]);
    for (int i = 0; i < 7; i++) begin
      wr(wa[i], wd[i]);
      rc(wa[i], we[i]);
    end
    // output selection at gain code 3 (counts times eight), trims off
    wr(8'h02, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(8'h01, mc[i]);
      amb(14'h0200, 14'h0080);
      rc(8'h04, {2'b00, mx[i][13:8]});
      rc(8'h05, mx[i][7:0]);
    end
    // trimmed green overflows: clamp, flag, pin; then read and disable clears
    wr(8'h0f, 8'hff);
    wr(8'h01, 8'h25);
    amb(14'h3000, 14'h0000);
    rc(8'h04, 8'h7f);
    chk({7'h00, irq_n}, 8'h00);
    rc(8'h00, 8'h01);
    chk({7'h00, irq_n}, 8'h01);
    amb(14'h3000, 14'h0000);
    wr(8'h01, 8'h24);
    chk({7'h00, irq_n}, 8'h01);
    rc(8'h00, 8'h00);
    // limit window at persist count zero: inside holds off, below the lower limit flags
    wr(8'h01, 8'h25);
    amb(14'h03fa, 14'h0000);
    rc(8'h00, 8'h00);
    amb(14'h0010, 14'h0000);
    rc(8'h00, 8'h01);
    // proximity with drive clamped, then with drive off
    wr(8'h03, 8'h0f);
    chk({4'h0, led_current_code}, 8'h0b);
    wr(8'h01, 8'h26);
    prox(8'h5a);
    chk({7'h00, both}, 8'h01);
    rc(8'h16, 8'h5a);
    chk({7'h00, irq_n}, 8'h00);
    rc(8'h00, 8'h02);
    wr(8'h03, 8'h00);
    prox(8'h33);
    chk({7'h00, lp}, 8'h00);
    rc(8'h16, 8'h33);
    // foreign bus address is not acknowledged
    host_u.start();
    host_u.byte_out(8'h22, nk);
    host_u.stop();
    chk({7'h00, nk}, 8'h01);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
